// ===== hdl/evlink_pkg.sv
// Shared types and constants for the event link converter.
// Assumes one system clock; the fast link word clock is only sampled.
package evlink_pkg;

	// One received fast link word as kept in the input buffer.
	typedef struct packed {
		logic first;
		logic last;
		logic [15:0] payload;
	} rx_word_t;

	// One character presented to the character link transmitter.
	typedef struct packed {
		logic is_ctrl;
		logic [7:0] code;
	} tx_char_t;

	// Status and error reporting towards the surrounding logic.
	typedef struct packed {
		logic in_event;
		logic overflow;
		logic [7:0] frame_errs;
	} link_status_t;

	// Control character numbers, all within the 14 available; values arbitrary.
	localparam logic [7:0] CTRL_START = 8'h01;
	localparam logic [7:0] CTRL_END = 8'h02;
	localparam logic [7:0] CTRL_FILL = 8'h05;
	localparam logic [7:0] CTRL_VIOL = 8'h07;
	localparam int CTRL_COUNT = 14;

	// Fill run between events, configurable within these bounds.
	localparam logic [2:0] GAP_MIN = 3'h2;
	localparam logic [2:0] GAP_MAX = 3'h4;

	// Input buffer geometry and word layout.
	localparam int WORD_W = 18;
	localparam int PTR_W = 4;
	localparam int DEPTH = 16;
	localparam logic [PTR_W:0] FIFO_CAP = 5'h10;

	// Link word clock period in ns, and its length in 100 ns system cycles.
	localparam int SYS_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int LINK_CYCLES = LINK_PERIOD_NS / SYS_PERIOD_NS;

	// Values after reset.
	localparam logic [7:0] ERRS_RESET = 8'h00;
	localparam logic [2:0] GAP_RESET = 3'h0;

	// Transmit sequencer states.
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_SOP = 3'b001,
		TX_HI = 3'b010,
		TX_LO = 3'b011,
		TX_WAIT = 3'b100,
		TX_EOP = 3'b101,
		TX_GAP = 3'b110
	} tx_state_t;

endpackage

// ===== hdl/event_link_converter.sv
// Event link converter: fast framed word link in, character link out.
// Assumes the word clock and its data, flags arrive asynchronously and are
// stable around the rising word clock edge; the character link takes one
// character per system clock.
//
// Notes on behaviour
// RL1: Two-state framing: start enters an event, end leaves it.
// RL2: Event start and event end use two distinct control characters.
// RL3: Between events only fill characters go out; the code also sends a requested violation character there.
// RL4: Fill inside an event is ignored and leaves payload intact.
// RL5: At least the configured two to four fills follow each event end.
// RL6: Far receiver resynchronises on two fills; no extra exchange sent.
// RL7: Payload passes unaltered, uninspected, with nothing added.
// RL8: No error for events that are not whole sixteen-byte multiples.
// RL9: Producers frame events as header, sixteen-byte payload, trailer.
// RL10: Input words are sixteen payload bits plus two protocol bits.
// RL11: One protocol bit flags the first word, the other the last.
// RL12: Input framing travels in data bits, not in control words.
// RL13: The input buffer is eighteen bits wide.
// RL14: Output characters are eight-bit data or one of fourteen controls.
// RL15: With nothing to send the transmitter emits fill.
// RL16: On request a violation control character is sent.
// RL17: The far receiver flags corrupted symbols as violations.
// RL18: The fast link runs its twenty-bit mode with alternating bit.
// RL19: Fast link fill words are treated as non-data.
// RL20: Fast link violation words are reported.
// RL21: First flag gives start char, words split in two, end after last.
// RL22: Words or violations between events are dropped and counted.
`timescale 1ns/1ns
module event_link_converter (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic rx_word_clk_i,
	input wire logic [15:0] rx_payload_i,
	input wire logic rx_first_i,
	input wire logic rx_last_i,
	input wire logic rx_fill_i,
	input wire logic rx_violation_i,
	input wire logic [2:0] gap_len_i,
	input wire logic viol_req_i,
	output evlink_pkg::tx_char_t tx_char_o,
	output evlink_pkg::link_status_t status_o
);
	import evlink_pkg::*;

	// Clamp the requested fill run into its legal window.
	function automatic logic [2:0] clamp_gap(input logic [2:0] req);
		if (req < GAP_MIN) begin
			return GAP_MIN;
		end else if (req > GAP_MAX) begin
			return GAP_MAX;
		end
		return req;
	endfunction

	// Wrap a buffer pointer.
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return PTR_W'(p + 1'b1);
	endfunction

	logic wclk_s1_reg;
	logic wclk_s2_reg;
	logic wclk_s3_reg;
	rx_word_t word_s1_reg;
	rx_word_t word_s2_reg;
	logic fill_s1_reg;
	logic fill_s2_reg;
	logic viol_s1_reg;
	logic viol_s2_reg;
	logic word_edge;

	// RL18: twenty-bit mode words
	// RL10: sixteen plus two flags
	// Every fast link pin passes two flops before use; the third clock flop only feeds
	// the edge detector so the first stage is never read by logic.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wclk_s1_reg <= 1'b0;
			wclk_s2_reg <= 1'b0;
			wclk_s3_reg <= 1'b0;
			word_s1_reg <= '0;
			word_s2_reg <= '0;
			fill_s1_reg <= 1'b0;
			fill_s2_reg <= 1'b0;
			viol_s1_reg <= 1'b0;
			viol_s2_reg <= 1'b0;
		end else begin
			wclk_s1_reg <= rx_word_clk_i;
			wclk_s2_reg <= wclk_s1_reg;
			wclk_s3_reg <= wclk_s2_reg;
			word_s1_reg <= '{first: rx_first_i, last: rx_last_i, payload: rx_payload_i};
			word_s2_reg <= word_s1_reg;
			fill_s1_reg <= rx_fill_i;
			fill_s2_reg <= fill_s1_reg;
			viol_s1_reg <= rx_violation_i;
			viol_s2_reg <= viol_s1_reg;
		end
	end

	// A rising word clock edge marks one received word.
	assign word_edge = wclk_s2_reg & ~wclk_s3_reg;

	logic in_event_reg;
	logic accept;
	logic discard;
	logic viol_seen;

	// RL19: fill words carry no data
	// RL11: first and last flags
	// RL12: framing from data bits
	always_comb begin
		accept = 1'b0;
		discard = 1'b0;
		viol_seen = word_edge & viol_s2_reg;
		if (word_edge && !fill_s2_reg && !viol_s2_reg) begin
			if (in_event_reg || word_s2_reg.first) begin
				accept = 1'b1;
			end else begin
				discard = 1'b1;
			end
		end
	end

	// RL1: two-state input framing
	// A word flagged first and last opens and closes the event at once.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			in_event_reg <= 1'b0;
		end else if (accept) begin
			in_event_reg <= ~word_s2_reg.last;
		end
	end

	// RL13: eighteen-bit buffer
	rx_word_t fifo_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] count_reg;
	logic fifo_full;
	logic fifo_empty;
	logic push;
	logic pop;
	rx_word_t head;

	assign fifo_full = (count_reg == FIFO_CAP);
	assign fifo_empty = (count_reg == '0);
	assign push = accept & ~fifo_full;
	assign head = fifo_mem[rd_ptr_reg];

	// Buffer storage; the write side has no back-pressure on the link.
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			fifo_mem[wr_ptr_reg] <= word_s2_reg;
		end
	end

	// Buffer pointers and fill level.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
			count_reg <= (PTR_W+1)'(count_reg + {4'h0, push} - {4'h0, pop});
		end
	end

	logic [7:0] errs_reg;
	logic overflow_reg;

	// RL22: count framing errors
	// RL20: report violation words
	// RL8: no length check
	// The counter saturates so a stuck link cannot wrap it back to zero.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			errs_reg <= ERRS_RESET;
		end else if ((discard || viol_seen) && errs_reg != 8'hff) begin
			errs_reg <= 8'(errs_reg + 1'b1);
		end
	end

	// Sticky overflow: the link cannot be stalled, so a lost word is flagged.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			overflow_reg <= 1'b0;
		end else if (accept && fifo_full) begin
			overflow_reg <= 1'b1;
		end
	end

	tx_state_t state_reg;
	tx_state_t state_next;
	rx_word_t word_reg;
	logic [2:0] gap_reg;
	logic viol_pend_reg;
	logic send_viol;
	tx_char_t char_next;

	assign send_viol = (state_reg == TX_IDLE) & viol_pend_reg;

	// RL21: start, split, end
	// RL7: payload passed unaltered
	// RL2: distinct start and end
	// RL14: eight-bit data characters
	always_comb begin
		state_next = state_reg;
		pop = 1'b0;
		char_next = '{is_ctrl: 1'b1, code: CTRL_FILL};
		case (state_reg)
			TX_IDLE: begin
				if (send_viol) begin
					char_next.code = CTRL_VIOL;
				end else if (!fifo_empty) begin
					pop = 1'b1;
					state_next = TX_SOP;
				end
			end
			TX_SOP: begin
				char_next.code = CTRL_START;
				state_next = TX_HI;
			end
			TX_HI: begin
				char_next = '{is_ctrl: 1'b0, code: word_reg.payload[15:8]};
				state_next = TX_LO;
			end
			TX_LO: begin
				char_next = '{is_ctrl: 1'b0, code: word_reg.payload[7:0]};
				if (word_reg.last) begin
					state_next = TX_EOP;
				end else if (!fifo_empty) begin
					pop = 1'b1;
					state_next = TX_HI;
				end else begin
					state_next = TX_WAIT;
				end
			end
			TX_WAIT: begin
				// RL4: fill inside event
				if (!fifo_empty) begin
					pop = 1'b1;
					state_next = TX_HI;
				end
			end
			TX_EOP: begin
				char_next.code = CTRL_END;
				state_next = TX_GAP;
			end
			TX_GAP: begin
				// RL5: mandatory fill run
				if (gap_reg == 3'h1) begin
					state_next = TX_IDLE;
				end
			end
			default: begin
				state_next = TX_IDLE;
			end
		endcase
	end

	// Sequencer state and the word being split.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= TX_IDLE;
			word_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (pop) begin
				word_reg <= head;
			end
		end
	end

	// RL5: load fill run
	// The length is taken at the end character, so a change mid-run waits.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			gap_reg <= GAP_RESET;
		end else if (state_reg == TX_EOP) begin
			gap_reg <= clamp_gap(gap_len_i);
		end else if (state_reg == TX_GAP) begin
			gap_reg <= 3'(gap_reg - 1'b1);
		end
	end

	// RL16: violation on request
	// A request is held until the link is between events; set beats clear.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			viol_pend_reg <= 1'b0;
		end else if (viol_req_i) begin
			viol_pend_reg <= 1'b1;
		end else if (send_viol) begin
			viol_pend_reg <= 1'b0;
		end
	end

	// RL3: only fill between events
	// RL15: fill when idle
	// Outputs are registered so the transceiver sees clean levels.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_char_o <= '{is_ctrl: 1'b1, code: CTRL_FILL};
			status_o <= '0;
		end else begin
			tx_char_o <= char_next;
			status_o <= '{in_event: in_event_reg, overflow: overflow_reg,
				frame_errs: errs_reg};
		end
	end

endmodule

// ===== verif/event_link_chk.sv
// Checker on the converter's character output and status.
// Sees only the converter's ports; bound to every instance of it.
`timescale 1ns/1ns
module event_link_chk
	import evlink_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] gap_len_i,
	input evlink_pkg::tx_char_t tx_char_o,
	input evlink_pkg::link_status_t status_o
);
	logic is_fill, is_start, is_end, is_viol;
	// Decode the output character once for all properties.
	assign is_fill = tx_char_o == {1'b1, CTRL_FILL};
	assign is_start = tx_char_o == {1'b1, CTRL_START};
	assign is_end = tx_char_o == {1'b1, CTRL_END};
	assign is_viol = tx_char_o == {1'b1, CTRL_VIOL};
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	ctrl_code_a: assert property (tx_char_o.is_ctrl |-> is_fill || is_start || is_end || is_viol)
		else $error("unknown control character");
	end_gap_a: assert property (is_end |=> is_fill [*2])
		else $error("short fill run after end");
	gap_three_a: assert property (is_end && $past(gap_len_i) > 3'h2 |=> is_fill [*3])
		else $error("fill run shorter than three");
	gap_four_a: assert property (is_end && $past(gap_len_i) > 3'h3 |=> is_fill [*4])
		else $error("fill run shorter than four");
	// fills before start; a requested violation may sit among them.
	start_gap_a: assert property (is_start |-> $past(is_fill) &&
		($past(is_fill, 2) || $past(is_viol, 2)) && ($past(is_fill, 3) || $past(is_viol, 3)))
		else $error("start without fill run");
	start_body_a: assert property (is_start |=> !is_end && !is_start)
		else $error("empty event");
	viol_idle_a: assert property (is_viol |-> $past(is_fill) || $past(is_viol))
		else $error("violation inside event");
	errs_mono_a: assert property (status_o.frame_errs >= $past(status_o.frame_errs))
		else $error("error count fell");
	ovf_sticky_a: assert property (status_o.overflow |=> status_o.overflow)
		else $error("overflow flag cleared");
	reset_out_a: assert property (disable iff (1'b0) sys_rst_i |=> is_fill && status_o == '0)
		else $error("output not idle in reset");
	// Main scenarios reached.
	cover property (is_start);
	cover property (is_end ##1 is_fill);
	cover property (is_viol);
	cover property (status_o.overflow);
endmodule
bind event_link_converter event_link_chk event_link_chk_inst (.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i), .gap_len_i(gap_len_i), .tx_char_o(tx_char_o),
	.status_o(status_o));

// ===== verif/fast_link_model.sv
// Model of the fast framed link receiver side feeding the converter.
// Assumes the bench calls send_word one word at a time.
`timescale 1ns/1ns
module fast_link_model (
	output logic word_clk_o,
	output logic [15:0] payload_o,
	output logic first_o,
	output logic last_o,
	output logic fill_o,
	output logic viol_o
);
	// The word clock stands still between words.
	initial begin
		word_clk_o = 1'b0;
		{first_o, last_o, fill_o, viol_o, payload_o} = '0;
	end
	// word format
	// One word per 800 ns, flags ride as data bits; data leads the edge by 300 ns.
	task automatic send_word(input logic f, input logic l, input logic fl, input logic v,
		input logic [15:0] p);
		// Non-blocking, so a change that falls on a system clock edge never races it.
		{first_o, last_o, fill_o, viol_o, payload_o} <= {f, l, fl, v, p};
		#300 word_clk_o <= 1'b1;
		#400 word_clk_o <= 1'b0;
		// Once hold time is over the lines no longer show the word.
		#60 {first_o, last_o, fill_o, viol_o, payload_o} <= ~{f, l, fl, v, p};
		#40;
	endtask
endmodule

// ===== verif/event_link_converter_tb.sv
// Self-checking bench for the event link converter.
// Assumes the checker binds itself and the link model drives the fast link.
`timescale 1ns/1ns
module event_link_converter_tb;
	import evlink_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [2:0] gap_len_i = 3'h0;
	logic viol_req_i = 1'b0;
	logic wclk, first, last, fill, viol;
	logic [15:0] payload;
	tx_char_t tx_char_o;
	link_status_t status_o;
	tx_char_t seen[$];
	tx_char_t want[$];
	int miscompares = 0;
	int checks = 0;
	int rx_viols = 0;
	int viol_reqs = 0;
	event_link_converter event_link_converter_inst (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .rx_word_clk_i(wclk), .rx_payload_i(payload),
		.rx_first_i(first), .rx_last_i(last), .rx_fill_i(fill), .rx_violation_i(viol),
		.gap_len_i(gap_len_i), .viol_req_i(viol_req_i), .tx_char_o(tx_char_o),
		.status_o(status_o));
	fast_link_model fast_link_model_inst (.word_clk_o(wclk), .payload_o(payload),
		.first_o(first), .last_o(last), .fill_o(fill), .viol_o(viol));
	// 10 MHz system clock.
	always #50 sys_clk_i = ~sys_clk_i;
	// no sync exchange: the modelled receiver takes any fill as idle.
	// Log every character but fill, so idle time does not matter.
	always @(posedge sys_clk_i) begin
		if (!sys_rst_i && tx_char_o !== {1'b1, CTRL_FILL}) begin
			seen.push_back(tx_char_o);
		end
		if (!sys_rst_i && tx_char_o === {1'b1, CTRL_VIOL}) begin
			rx_viols++;
		end
	end
	function automatic tx_char_t ctl(input logic [7:0] c);
		return {1'b1, c};
	endfunction
	function automatic tx_char_t dat(input logic [7:0] b);
		return {1'b0, b};
	endfunction
	task automatic chk_char(input string what, input tx_char_t e, input tx_char_t g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_bit(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_cnt(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Let the output settle, compare the log with the expected list, clear both.
	task automatic drain;
		repeat (30) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk_bit("in event", 1'b0, status_o.in_event);
		chk_cnt("char count", 8'(want.size()), 8'(seen.size()));
		foreach (want[i]) begin
			chk_char("char", want[i], (i < seen.size()) ? seen[i] : ctl(8'h00));
		end
		want = {};
		seen = {};
	endtask
	task automatic pulse_viol;
		@(posedge sys_clk_i);
		viol_req_i <= 1'b1;
		viol_reqs++;
		@(posedge sys_clk_i);
		viol_req_i <= 1'b0;
	endtask
	// A hang ends the run as a failure.
	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end
	initial begin
		logic [15:0] p;
		int n;
		void'($urandom(41187));
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk_char("idle char", ctl(CTRL_FILL), tx_char_o);
		// Events of random length, the first a single word flagged first and last.
		for (int e = 0; e < 6; e++) begin
			@(posedge sys_clk_i);
			gap_len_i <= 3'($urandom_range(7));
			// event 1 is framed as producers do: 12 + 16 + 4 bytes, 16 words.
			n = (e == 0) ? 1 : (e == 1) ? 16 : int'($urandom_range(6, 1));
			want.push_back(ctl(CTRL_START));
			for (int i = 0; i < n; i++) begin
				p = 16'($urandom);
				fast_link_model_inst.send_word(i == 0, i == n - 1, 1'b0, 1'b0, p);
				want.push_back(dat(p[15:8]));
				want.push_back(dat(p[7:0]));
				// The first word of a longer event leaves the framing state inside.
				if (i == 0 && n > 1) begin
					@(negedge sys_clk_i);
					chk_bit("in event", 1'b1, status_o.in_event);
				end
				if (i < n - 1 && $urandom_range(1)) begin
					fast_link_model_inst.send_word(1'b0, 1'b0, 1'b1, 1'b0, ~p);
				end
				// A request in mid-event must wait for the gap.
				if (e == 5 && i == 0) begin
					pulse_viol();
				end
			end
			want.push_back(ctl(CTRL_END));
			if (e == 5) begin
				want.push_back(ctl(CTRL_VIOL));
			end
			drain();
		end
		chk_cnt("errs after odd sizes", ERRS_RESET, status_o.frame_errs);
		// One-word events with the longest gap take nine cycles against eight on
		// the link, so the buffer slowly fills and a word is lost.
		@(posedge sys_clk_i);
		gap_len_i <= 3'h7;
		repeat (200) begin
			fast_link_model_inst.send_word(1'b1, 1'b1, 1'b0, 1'b0, 16'($urandom));
		end
		@(negedge sys_clk_i);
		chk_bit("overflow", 1'b1, status_o.overflow);
		// A second reset in mid-run clears buffer, status and output.
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk_char("char after reset", ctl(CTRL_FILL), tx_char_o);
		chk_bit("overflow after reset", 1'b0, status_o.overflow);
		chk_cnt("errs after reset", ERRS_RESET, status_o.frame_errs);
		repeat (20) @(posedge sys_clk_i);
		want = {};
		seen = {};
		// Stray data and a violation word between events are dropped and counted.
		fast_link_model_inst.send_word(1'b0, 1'b0, 1'b0, 1'b0, 16'h1234);
		fast_link_model_inst.send_word(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
		fast_link_model_inst.send_word(1'b0, 1'b0, 1'b1, 1'b0, 16'hffff);
		drain();
		chk_cnt("frame errs", 8'h02, status_o.frame_errs);
		pulse_viol();
		want.push_back(ctl(CTRL_VIOL));
		drain();
		chk_cnt("viol chars", 8'(viol_reqs), 8'(rx_viols));
		print_verdict();
	end
endmodule
